// [rtl/pecb_consts.svh]
// Offsets, field positions, reset values and bit counts of the PHY counter and self-test block.
`ifndef PECB_CONSTS_SVH
`define PECB_CONSTS_SVH

// ==========================================================================
// Register indices; the APB byte address is four times the index.
`define PECB_IDX_FC_TALLY   6'h14
`define PECB_IDX_RE_TALLY   6'h15
`define PECB_IDX_SELF_TEST  6'h16
`define PECB_IDX_IRQ_STATUS 6'h18
`define PECB_IDX_IRQ_MASK   6'h19
`define PECB_IDX_BIST_ERR   6'h1A

// ==========================================================================
// Field positions.
`define PECB_CTL_CONT_BIT   14
`define PECB_CTL_PRBS_BIT   13
`define PECB_CTL_GEN_BIT    12
`define PECB_CTL_LOCK_BIT   11
`define PECB_CTL_LOSS_BIT   10
`define PECB_IRQ_FC_BIT     9
`define PECB_IRQ_RE_BIT     8

// ==========================================================================
// Widths, reset values and the constant packet byte.
`define PECB_FC_WIDTH       8
`define PECB_RE_WIDTH       16
`define PECB_ERR_WIDTH      16
`define PECB_CTL_RESET      3'h0
`define PECB_MASK_RESET     2'h0
`define PECB_CONST_BYTE     8'h55

// ==========================================================================
// Bit counts of the packet generator and checker.
`define PECB_PKT_BITS       512
`define PECB_GAP_BITS       96
`define PECB_LOCK_BITS      32

`endif

// [rtl/pecb_pkg.sv]
// Types shared by the PHY counter and self-test block.
package pecb_pkg;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_SEND = 2'b01,
    GEN_GAP  = 2'b10,
    GEN_DONE = 2'b11
  } pecb_gen_state_t;

  typedef logic [14:0] pecb_lfsr_t;

endpackage : pecb_pkg

// [rtl/pecb_tally_if.sv]
// Interface between the register logic and one saturating tally.
`timescale 1ns/1ps

interface pecb_tally_if #(parameter int WIDTH = 8);
  logic             inc;
  logic             rd_clr;
  logic [WIDTH-1:0] count;
  logic             half_evt;

  modport counter (input inc, input rd_clr, output count, output half_evt);
  modport owner   (output inc, output rd_clr, input count, input half_evt);
endinterface : pecb_tally_if

// [rtl/pecb_sat_counter.sv]
// Saturating clear-on-read tally with a half-full event.
`timescale 1ns/1ps

module pecb_sat_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  pecb_tally_if.counter    tally
);

  localparam logic [WIDTH-1:0] MAX_VAL  = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] HALF_VAL = {1'b0, {(WIDTH-1){1'b1}}};

  if (WIDTH < 2)
  begin : g_check
    $error("pecb_sat_counter needs WIDTH of at least 2");
  end

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             half_q;
  logic             half_d;

  // ==========================================================================
  // Next count
  // A read clears first; an event in the same cycle is then counted so none is lost.
  always_comb
  begin
    count_d = tally.rd_clr ? '0 : count_q;
    if (tally.inc && (count_d != MAX_VAL))
    begin
      count_d = count_d + 1'b1;
    end
    half_d = (count_d > HALF_VAL) && (count_q <= HALF_VAL);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q <= '0;
      half_q  <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      half_q  <= half_d;
    end
  end

  assign tally.count    = count_q;
  assign tally.half_evt = half_q;

endmodule : pecb_sat_counter

// [rtl/pecb_top.sv]
// PHY statistics counters and self-test control with an APB register slave.
//
// Overview of operation
// (R1) Reserved false-carrier bits 15:8 and self-test bit 15 read zero, ignore writes.
// (R2) Eight-bit false-carrier tally counts each false carrier event by one.
// (R3) False-carrier tally holds at 0xFF.
// (R4) False-carrier tally passing 0x7F raises a half-full event.
// (R5) Reading the false-carrier register returns the tally, then zeroes it.
// (R6) Sixteen-bit receive-error tally counts errors with data valid, carrier, bad symbol.
// (R7) No receive-error counting while MII loopback is active.
// (R8) Receive-error tally holds at 0xFFFF without wrapping.
// (R9) Receive-error tally passing 0x7FFF raises a half-full event.
// (R10) Reading the receive-error register returns the tally, then zeroes it.
// (R11) Continuous mode: error counter pulses at maximum and restarts from zero.
// (R12) Single mode: checker stops counting once the error counter reaches maximum.
// (R13) PRBS mode: generator sends continuous PRBS packets; checker stays active.
// (R14) Constant mode: generator sends one constant packet; PRBS generation, checking off.
// (R15) Bit 12 enables the packet generator; it resets to zero.
// (R16) Bit 11 reads one while the checker is locked.
// (R17) Bit 10 latches one when the checker loses sync.
// (R18) Reading clears the sync-loss bit unless sync is still lost.
// (R19) Half-full events set clear-on-read pending flags, each gated by its enable.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "pecb_consts.svh"

module pecb_top #(
  parameter int unsigned PKT_BITS  = `PECB_PKT_BITS,
  parameter int unsigned GAP_BITS  = `PECB_GAP_BITS,
  parameter int unsigned LOCK_BITS = `PECB_LOCK_BITS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        false_carrier_evt,
  input  wire logic        rx_dv,
  input  wire logic        rx_carrier_valid,
  input  wire logic        rx_invalid_symbol,
  input  wire logic        mii_loopback,
  input  wire logic        rx_bit,
  output logic             tx_en,
  output logic             tx_bit,
  output logic             prbs_max_pulse,
  output logic             irq
);

  if ((PKT_BITS < 8) || (PKT_BITS > 65535) || (GAP_BITS < 1) || (GAP_BITS > 65535)
      || (LOCK_BITS < 2) || (LOCK_BITS > 255))
  begin : g_check
    $error("pecb_top bit counts out of range");
  end

  localparam logic [15:0] PKT_LAST  = 16'(PKT_BITS - 1);
  localparam logic [15:0] GAP_LAST  = 16'(GAP_BITS - 1);
  localparam logic [7:0]  LOCK_LAST = 8'(LOCK_BITS - 1);
  localparam logic [`PECB_ERR_WIDTH-1:0] ERR_MAX = {`PECB_ERR_WIDTH{1'b1}};
  localparam logic [7:0]  CONST_BYTE = `PECB_CONST_BYTE;

  // ==========================================================================
  // APB decode
  // Read data is captured in the setup cycle, and the clear-on-read effects act at
  // that same edge, so an event arriving during the access phase lands in the new tally.
  logic        setup;
  logic        access;
  logic [5:0]  idx;
  logic        hit_fc;
  logic        hit_re;
  logic        hit_ctl;
  logic        hit_ist;
  logic        hit_msk;
  logic        hit_err;
  logic        mapped;
  logic        rd_setup;
  logic        wr_access;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        err_q;
  logic        err_d;

  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign idx       = paddr[7:2];
  assign hit_fc    = (idx == `PECB_IDX_FC_TALLY);
  assign hit_re    = (idx == `PECB_IDX_RE_TALLY);
  assign hit_ctl   = (idx == `PECB_IDX_SELF_TEST);
  assign hit_ist   = (idx == `PECB_IDX_IRQ_STATUS);
  assign hit_msk   = (idx == `PECB_IDX_IRQ_MASK);
  assign hit_err   = (idx == `PECB_IDX_BIST_ERR);
  assign mapped    = (paddr[1:0] == 2'h0)
                     && (hit_fc || hit_re || hit_ctl || hit_ist || hit_msk || hit_err);
  assign rd_setup  = setup && !pwrite && mapped;
  assign wr_access = access && pwrite && !err_q;

  assign pready  = 1'b1;
  assign pslverr = access && err_q;
  assign prdata  = prdata_q;

  // ==========================================================================
  // Control and mask registers
  logic [2:0] ctl_q;
  logic [2:0] ctl_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic       prbs_mode;
  logic       gen_enable;
  logic       cont_mode;

  // Only control bits 14:12 and mask bits 9:8 are writable; reserved and status bits drop writes.
  always_comb
  begin
    ctl_d  = ctl_q;
    mask_d = mask_q;
    if (wr_access && hit_ctl)
    begin
      ctl_d = pwdata[`PECB_CTL_CONT_BIT:`PECB_CTL_GEN_BIT]; // R1 R15
    end
    if (wr_access && hit_msk)
    begin
      mask_d = pwdata[`PECB_IRQ_FC_BIT:`PECB_IRQ_RE_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctl_q  <= `PECB_CTL_RESET; // R15
      mask_q <= `PECB_MASK_RESET;
    end
    else
    begin
      ctl_q  <= ctl_d;
      mask_q <= mask_d;
    end
  end

  assign cont_mode  = ctl_q[2];
  assign prbs_mode  = ctl_q[1];
  assign gen_enable = ctl_q[0];

  // ==========================================================================
  // Statistics tallies
  pecb_tally_if #(.WIDTH(`PECB_FC_WIDTH)) fc_if ();
  pecb_tally_if #(.WIDTH(`PECB_RE_WIDTH)) re_if ();

  assign fc_if.inc    = false_carrier_evt; // R2
  assign fc_if.rd_clr = rd_setup && hit_fc; // R5
  assign re_if.inc    = rx_dv && rx_carrier_valid && rx_invalid_symbol && !mii_loopback; // R6 R7
  assign re_if.rd_clr = rd_setup && hit_re; // R10

  // Saturation and the half-full crossing live in the counter module.
  pecb_sat_counter #(.WIDTH(`PECB_FC_WIDTH)) u_fc_tally ( // R3 R4
    .clk     (clk),
    .reset_n (reset_n),
    .tally   (fc_if)
  );

  pecb_sat_counter #(.WIDTH(`PECB_RE_WIDTH)) u_re_tally ( // R8 R9
    .clk     (clk),
    .reset_n (reset_n),
    .tally   (re_if)
  );

  // ==========================================================================
  // Interrupt pending flags
  logic [1:0] ist_q;
  logic [1:0] ist_d;
  logic [1:0] ist_set;
  logic [1:0] ist_clr;

  assign ist_set = {fc_if.half_evt, re_if.half_evt};

  // A read clears both flags and a write of one clears that flag; a new event wins.
  always_comb
  begin
    ist_clr = '0;
    if (rd_setup && hit_ist)
    begin
      ist_clr = 2'h3;
    end
    if (wr_access && hit_ist)
    begin
      ist_clr = ist_clr | pwdata[`PECB_IRQ_FC_BIT:`PECB_IRQ_RE_BIT];
    end
    ist_d = (ist_q & ~ist_clr) | ist_set; // R19
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ist_q <= '0;
    end
    else
    begin
      ist_q <= ist_d;
    end
  end

  assign irq = |(ist_q & mask_q); // R19

  // ==========================================================================
  // Packet generator
  pecb_pkg::pecb_gen_state_t gen_state_q;
  pecb_pkg::pecb_gen_state_t gen_state_d;
  logic [15:0]       bit_cnt_q;
  logic [15:0]       bit_cnt_d;
  logic              tx_en_q;
  logic              tx_en_d;
  logic              tx_bit_q;
  logic              tx_bit_d;
  pecb_pkg::pecb_lfsr_t gen_lfsr_q;
  pecb_pkg::pecb_lfsr_t gen_lfsr_d;
  logic              gen_prbs_bit;

  assign gen_prbs_bit = gen_lfsr_q[14] ^ gen_lfsr_q[13];

  always_comb
  begin
    gen_state_d = gen_state_q;
    bit_cnt_d   = bit_cnt_q;
    tx_en_d     = 1'b0;
    tx_bit_d    = 1'b0;
    gen_lfsr_d  = gen_lfsr_q;
    case (gen_state_q)
      pecb_pkg::GEN_IDLE:
      begin
        bit_cnt_d = '0;
        if (gen_enable)
        begin
          gen_state_d = pecb_pkg::GEN_SEND;
        end
      end
      pecb_pkg::GEN_SEND:
      begin
        tx_en_d   = 1'b1;
        bit_cnt_d = bit_cnt_q + 16'h1;
        if (prbs_mode)
        begin
          tx_bit_d   = gen_prbs_bit; // R13
          gen_lfsr_d = {gen_lfsr_q[13:0], gen_prbs_bit};
        end
        else
        begin
          tx_bit_d = CONST_BYTE[bit_cnt_q[2:0]]; // R14
        end
        if (bit_cnt_q == PKT_LAST)
        begin
          bit_cnt_d   = '0;
          gen_state_d = prbs_mode ? pecb_pkg::GEN_GAP : pecb_pkg::GEN_DONE; // R13 R14
        end
      end
      pecb_pkg::GEN_GAP:
      begin
        bit_cnt_d = bit_cnt_q + 16'h1;
        if (bit_cnt_q == GAP_LAST)
        begin
          bit_cnt_d   = '0;
          gen_state_d = prbs_mode ? pecb_pkg::GEN_SEND : pecb_pkg::GEN_DONE;
        end
      end
      pecb_pkg::GEN_DONE:
      begin
        bit_cnt_d = '0;
      end
      default:
      begin
        gen_state_d = pecb_pkg::GEN_IDLE;
      end
    endcase
    if (!gen_enable)
    begin
      gen_state_d = pecb_pkg::GEN_IDLE; // R15
      tx_en_d     = 1'b0;
      tx_bit_d    = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gen_state_q <= pecb_pkg::GEN_IDLE;
      bit_cnt_q   <= '0;
      tx_en_q     <= 1'b0;
      tx_bit_q    <= 1'b0;
      gen_lfsr_q  <= 15'h7FFF;
    end
    else
    begin
      gen_state_q <= gen_state_d;
      bit_cnt_q   <= bit_cnt_d;
      tx_en_q     <= tx_en_d;
      tx_bit_q    <= tx_bit_d;
      gen_lfsr_q  <= gen_lfsr_d;
    end
  end

  assign tx_en  = tx_en_q;
  assign tx_bit = tx_bit_q;

  // ==========================================================================
  // PRBS checker
  // The checker predicts each bit from the last fifteen received, so it needs no seed;
  // a single bit error therefore drops lock, a deliberate simplicity.
  logic                        chk_active;
  logic                        chk_run;
  logic [14:0]                 hist_q;
  logic [14:0]                 hist_d;
  logic [7:0]                  good_q;
  logic [7:0]                  good_d;
  logic                        lock_q;
  logic                        lock_d;
  logic                        loss_q;
  logic                        loss_d;
  logic [`PECB_ERR_WIDTH-1:0]  err_cnt_q;
  logic [`PECB_ERR_WIDTH-1:0]  err_cnt_d;
  logic                        max_pulse_q;
  logic                        max_pulse_d;
  logic                        match;
  logic                        bit_err;

  assign chk_active = prbs_mode; // R13 R14
  assign chk_run    = chk_active && !(!cont_mode && (err_cnt_q == ERR_MAX)); // R12
  assign match      = (rx_bit == (hist_q[14] ^ hist_q[13]));
  assign bit_err    = chk_run && lock_q && !match;

  always_comb
  begin
    hist_d      = hist_q;
    good_d      = good_q;
    lock_d      = lock_q;
    err_cnt_d   = err_cnt_q;
    max_pulse_d = 1'b0;
    if (!chk_active)
    begin
      good_d = '0;
      lock_d = 1'b0;
    end
    else if (chk_run)
    begin
      hist_d = {hist_q[13:0], rx_bit};
      if (!match)
      begin
        good_d = '0;
        lock_d = 1'b0;
      end
      else if (good_q == LOCK_LAST)
      begin
        lock_d = 1'b1; // R16
      end
      else
      begin
        good_d = good_q + 8'h1;
      end
      if (bit_err)
      begin
        if (err_cnt_q == ERR_MAX)
        begin
          err_cnt_d   = '0; // R11
          max_pulse_d = 1'b1; // R11
        end
        else
        begin
          err_cnt_d = err_cnt_q + 1'b1;
        end
      end
    end
    // Loss stays set on a read while the checker is active without lock.
    loss_d = loss_q;
    if (rd_setup && hit_ctl && !(chk_active && !lock_q))
    begin
      loss_d = 1'b0; // R18
    end
    if (lock_q && !lock_d)
    begin
      loss_d = 1'b1; // R17
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hist_q      <= '0;
      good_q      <= '0;
      lock_q      <= 1'b0;
      loss_q      <= 1'b0;
      err_cnt_q   <= '0;
      max_pulse_q <= 1'b0;
    end
    else
    begin
      hist_q      <= hist_d;
      good_q      <= good_d;
      lock_q      <= lock_d;
      loss_q      <= loss_d;
      err_cnt_q   <= err_cnt_d;
      max_pulse_q <= max_pulse_d;
    end
  end

  assign prbs_max_pulse = max_pulse_q;

  // ==========================================================================
  // Read data and slave error
  always_comb
  begin
    prdata_d = prdata_q;
    err_d    = err_q;
    if (setup)
    begin
      prdata_d = '0;
      err_d    = !mapped;
      if (!pwrite && mapped)
      begin
        if (hit_fc)
        begin
          prdata_d[`PECB_FC_WIDTH-1:0] = fc_if.count; // R1 R5
        end
        if (hit_re)
        begin
          prdata_d[`PECB_RE_WIDTH-1:0] = re_if.count; // R10
        end
        if (hit_ctl)
        begin
          prdata_d[`PECB_CTL_CONT_BIT:`PECB_CTL_GEN_BIT] = ctl_q; // R1
          prdata_d[`PECB_CTL_LOCK_BIT] = lock_q; // R16
          prdata_d[`PECB_CTL_LOSS_BIT] = loss_q; // R17
        end
        if (hit_ist)
        begin
          prdata_d[`PECB_IRQ_FC_BIT:`PECB_IRQ_RE_BIT] = ist_q;
        end
        if (hit_msk)
        begin
          prdata_d[`PECB_IRQ_FC_BIT:`PECB_IRQ_RE_BIT] = mask_q;
        end
        if (hit_err)
        begin
          prdata_d[`PECB_ERR_WIDTH-1:0] = err_cnt_q;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_q <= '0;
      err_q    <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      err_q    <= err_d;
    end
  end

endmodule : pecb_top

// [test/pecb_top_props.sv]
// Port checker of the PHY counter and self-test block.
`timescale 1ns/1ps
`include "pecb_consts.svh"

module pecb_top_props #(
  parameter int unsigned PKT_BITS  = 512,
  parameter int unsigned GAP_BITS  = 96,
  parameter int unsigned LOCK_BITS = 32
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_en,
  input wire logic        tx_bit,
  input wire logic        irq
);
  localparam logic [7:0] A_FC = {`PECB_IDX_FC_TALLY, 2'b00};
  localparam logic [7:0] A_ST = {`PECB_IDX_SELF_TEST, 2'b00};
  localparam logic [7:0] A_MK = {`PECB_IDX_IRQ_MASK, 2'b00};
  logic        acc;
  logic        gen_q, gen_d, prbs_q, prbs_d;
  logic [1:0]  mask_q, mask_d;
  logic [15:0] run_q, run_d;

  // ==========================================================================
  // Shadow of the control fields, taken at the same edge as the design.
  assign acc = psel && penable && pready;
  always_comb
  begin
    gen_d  = gen_q;
    prbs_d = prbs_q;
    mask_d = mask_q;
    if (acc && pwrite && paddr == A_ST)
    begin
      gen_d  = pwdata[12];
      prbs_d = pwdata[13];
    end
    if (acc && pwrite && paddr == A_MK)
      mask_d = pwdata[9:8];
    run_d = tx_en ? run_q + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      gen_q  <= 1'b0;
      prbs_q <= 1'b0;
      mask_q <= 2'h0;
      run_q  <= 16'h0;
    end
    else
    begin
      gen_q  <= gen_d;
      prbs_q <= prbs_d;
      mask_q <= mask_d;
      run_q  <= run_d;
    end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ready_high: assert property (psel |-> pready) else $error("pready low");
  a_err_align: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  a_err_phase: assert property (!penable |-> !pslverr) else $error("pslverr outside access");
  a_fc_resv: assert property (acc && !pwrite && paddr == A_FC |-> prdata[31:8] == 24'h0)
    else $error("false carrier reserved bits set");
  a_ctl_resv: assert property (acc && !pwrite && paddr == A_ST |-> prdata[31:15] == 17'h0)
    else $error("control reserved bits set");
  a_gen_stop: assert property (!gen_q |=> !tx_en) else $error("sending while disabled");
  a_gen_start: assert property ($rose(gen_q) |-> ##[1:4] tx_en)
    else $error("generator did not start");
  a_pkt_len: assert property ($fell(tx_en) && gen_q |-> run_q == PKT_BITS)
    else $error("packet length wrong");
  a_const_first: assert property ($rose(tx_en) && !prbs_q |-> tx_bit)
    else $error("constant packet first bit wrong");
  a_const_alt: assert property (tx_en && $past(tx_en) && !prbs_q |-> tx_bit != $past(tx_bit))
    else $error("constant pattern broken");
  a_const_once: assert property ($fell(tx_en) && gen_q && !prbs_q |=> !tx_en [*8])
    else $error("second constant packet");
  a_prbs_again: assert property ($fell(tx_en) && gen_q && prbs_q |-> ##[1:200] (tx_en || !gen_q))
    else $error("packets not continuous");
  a_irq_mask: assert property (mask_q == 2'h0 |-> !irq) else $error("masked irq");
endmodule : pecb_top_props

bind pecb_top pecb_top_props #(
  .PKT_BITS(PKT_BITS), .GAP_BITS(GAP_BITS), .LOCK_BITS(LOCK_BITS)
) props_u (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_en(tx_en), .tx_bit(tx_bit), .irq(irq)
);

// [test/pecb_line_model.sv]
// Line partner that loops the transmitted bit stream back to the receiver.
`timescale 1ns/1ps

module pecb_line_model (
  input  wire logic clk,
  input  wire logic tx_en,
  input  wire logic tx_bit,
  output logic      rx_bit
);
  logic last_q = 1'b0;

  // An idle line holds no data; a toggling pattern keeps a stale bit from looking valid.
  always @(posedge clk)
    last_q <= rx_bit;
  assign rx_bit = tx_en ? tx_bit : ~last_q;
endmodule : pecb_line_model

// [test/tb_pecb_top.sv]
// Self-checking testbench of the PHY counter and self-test block.
`timescale 1ns/1ps
`include "pecb_consts.svh"

module tb_pecb_top;
  localparam int PKT = 48;
  localparam logic [7:0] A_FC = {`PECB_IDX_FC_TALLY, 2'b00};
  localparam logic [7:0] A_RE = {`PECB_IDX_RE_TALLY, 2'b00};
  localparam logic [7:0] A_ST = {`PECB_IDX_SELF_TEST, 2'b00};
  localparam logic [7:0] A_IS = {`PECB_IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] A_MK = {`PECB_IDX_IRQ_MASK, 2'b00};
  logic        clk, reset_n, psel, penable, pwrite, fc_evt, dv, car, inv, lpbk;
  logic        pready, pslverr, rx_bit, tx_en, tx_bit, max_p, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  r;
  logic [15:0] ecnt;
  logic [32:0] exp_q[$];
  int          n_errors = 0, n_tests = 0, seed = 51, cyc = 0, n;

  pecb_top #(.PKT_BITS(PKT), .GAP_BITS(2), .LOCK_BITS(4)) dut_u (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .false_carrier_evt(fc_evt), .rx_dv(dv), .rx_carrier_valid(car),
    .rx_invalid_symbol(inv), .mii_loopback(lpbk), .rx_bit(rx_bit), .tx_en(tx_en),
    .tx_bit(tx_bit), .prbs_max_pulse(max_p), .irq(irq)
  );
  pecb_line_model line_u (.clk(clk), .tx_en(tx_en), .tx_bit(tx_bit), .rx_bit(rx_bit));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Checking, closing and bus tasks.
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic ev(input logic re, input int k);
    repeat (k)
    begin
      @(posedge clk);
      fc_evt <= !re;
      {dv, car, inv} <= {3{re}};
    end
    @(posedge clk);
    {fc_evt, dv, car, inv} <= 4'h0;
    repeat (3) @(negedge clk);
  endtask : ev

  task automatic wait_tx(input logic v);
    n = 0;
    while (tx_en !== v && n < 300)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_tx

  // Read data is taken at the access edge, where pready is sampled high.
  always @(posedge clk)
    if (psel && penable && pready && !pwrite)
    begin
      if (exp_q.size() == 0)
        check("read queue", 33'h0, 33'h1);
      else
        check("read word", {pslverr, prdata}, exp_q.pop_front());
    end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_errors++;
      finish_test();
    end
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    {psel, penable, pwrite, fc_evt, dv, car, inv, lpbk} = 8'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(A_ST, 32'h0, 1'b0);
    apb(1'b1, A_ST, 32'hFFFF_8000);
    rd(A_ST, 32'h0, 1'b0);
    apb(1'b1, A_FC, 32'hFFFF_FFFF);
    rd(A_FC, 32'h0, 1'b0);
    rd(8'h5C, 32'h0, 1'b1);
    rd(8'h51, 32'h0, 1'b1);
    $display("test map done");
    n = 1 + ($unsigned($random(seed)) % 20);
    ev(1'b0, n);
    rd(A_FC, 32'(n), 1'b0);
    rd(A_FC, 32'h0, 1'b0);
    apb(1'b1, A_MK, 32'h300);
    rd(A_MK, 32'h300, 1'b0);
    ev(1'b0, 127);
    check("irq", {32'h0, irq}, 33'h0);
    ev(1'b0, 1);
    check("irq", {32'h0, irq}, 33'h1);
    rd(A_IS, 32'h200, 1'b0);
    ev(1'b0, 200);
    rd(A_FC, 32'hFF, 1'b0);
    $display("test false carrier done");
    ecnt = 16'h0;
    repeat (200)
    begin
      @(posedge clk);
      r = 4'($random(seed));
      {dv, car, inv, lpbk} <= r;
      ecnt = ecnt + 16'(r[3] & r[2] & r[1] & !r[0]);
    end
    @(posedge clk);
    {dv, car, inv, lpbk} <= 4'h0;
    rd(A_RE, {16'h0, ecnt}, 1'b0);
    ev(1'b1, 32'h7FFF);
    check("irq", {32'h0, irq}, 33'h0);
    ev(1'b1, 1);
    check("irq", {32'h0, irq}, 33'h1);
    rd(A_IS, 32'h100, 1'b0);
    ev(1'b1, 32'h8000);
    rd(A_RE, 32'hFFFF, 1'b0);
    rd(A_RE, 32'h0, 1'b0);
    $display("test receive error done");
    apb(1'b1, A_ST, 32'h1000);
    wait_tx(1'b1);
    check("first bit", {32'h0, tx_bit}, 33'h1);
    wait_tx(1'b0);
    check("packet length", 33'(n), 33'(PKT));
    repeat (20) @(negedge clk);
    check("single packet", {32'h0, tx_en}, 33'h0);
    apb(1'b1, A_ST, 32'h0);
    apb(1'b1, A_ST, 32'h3000);
    wait_tx(1'b1);
    repeat (30) @(negedge clk);
    rd(A_ST, 32'h3C00, 1'b0);
    wait_tx(1'b0);
    wait_tx(1'b1);
    check("second packet", {32'h0, tx_en}, 33'h1);
    apb(1'b1, A_ST, 32'h2000);
    repeat (10) @(negedge clk);
    rd(A_ST, 32'h2400, 1'b0);
    rd(A_ST, 32'h2400, 1'b0);
    apb(1'b1, A_ST, 32'h0);
    rd(A_ST, 32'h0400, 1'b0);
    rd(A_ST, 32'h0, 1'b0);
    rd(8'h68, 32'h3, 1'b0);
    apb(1'b1, A_ST, 32'h4000);
    rd(A_ST, 32'h4000, 1'b0);
    check("max pulse", {32'h0, max_p}, 33'h0);
    $display("test self test done");
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule : tb_pecb_top
